// ---- hdl/fsr_pkg.sv ----
// Shared constants and carrier types for the flash status register logic
package fsr_pkg;

	// Command opcodes seen on the serial port
	localparam logic [7:0] OPC_READ_STATUS = 8'h05;
	localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;

	// Status write data byte layout
	localparam int WR_LOCK_BIT = 7;
	localparam int WR_GLOBAL_HI = 5;
	localparam int WR_GLOBAL_LO = 2;

	// Global field codes that trigger an array-wide action
	localparam logic [3:0] GLOBAL_PROTECT_CODE = 4'hF;
	localparam logic [3:0] GLOBAL_UNPROTECT_CODE = 4'h0;

	// Protection summary codes
	localparam logic [1:0] SUMMARY_NONE = 2'h0;
	localparam logic [1:0] SUMMARY_SOME = 2'h1;
	localparam logic [1:0] SUMMARY_ALL = 2'h3;

	// Bit counter of the serial port
	localparam logic [2:0] BIT_CNT_RESET = 3'h0;
	localparam logic [2:0] BIT_CNT_LAST = 3'h7;
	localparam logic [2:0] BIT_CNT_STEP = 3'h1;
	localparam logic [2:0] SER_IDX_FIRST = 3'h7;

	// Reset values of the held flags
	localparam logic LOCK_RESET = 1'b0;
	localparam logic WEL_RESET = 1'b0;
	localparam logic EPE_RESET = 1'b0;
	localparam logic SEQ_RESET = 1'b0;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic BUSY_RESET = 1'b0;
	localparam logic PULSE_RESET = 1'b0;
	localparam logic SO_RESET = 1'b0;
	// Idle levels of the serial pins, so no false edge follows reset
	localparam logic SCK_IDLE = 1'b0;
	localparam logic CS_IDLE_N = 1'b1;

	// Frame decoder states
	typedef enum logic [2:0] {
		FSR_ST_OPCODE = 3'b000,
		FSR_ST_READ = 3'b001,
		FSR_ST_WR_DATA = 3'b010,
		FSR_ST_WR_FULL = 3'b011,
		FSR_ST_WEN = 3'b100,
		FSR_ST_WDIS = 3'b101,
		FSR_ST_OTHER = 3'b110
	} fsr_state_t;

	// Status byte as shifted out, bit 7 first
	typedef struct packed {
		logic protection_lock;
		logic sequential_program_flag;
		logic erase_program_error;
		logic write_protect_pin_state;
		logic [1:0] protection_summary;
		logic write_enable_latch;
		logic busy_flag;
	} fsr_status_t;

	// Events reported by the array program and erase engines
	typedef struct packed {
		logic busy;
		logic op_done;
		logic op_fail;
		logic seq_enter;
		logic seq_exit;
		logic wel_clear;
		logic all_protected;
		logic any_protected;
	} fsr_engine_t;

endpackage

// ---- hdl/fsr_status_serializer.sv ----
// Shifts the status byte out MSB first, taking a fresh snapshot per byte
`timescale 1ns/10ps
module fsr_status_serializer (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Control
	input wire logic active,
	input wire logic shift_en,
	// Data
	input wire fsr_pkg::fsr_status_t status_in,
	output logic so_out
);

	logic [2:0] idx_reg; // Bit being presented next
	logic [2:0] idx_next;
	logic [7:0] snap_reg; // Byte frozen at its first bit
	logic [7:0] snap_next;
	logic so_reg; // Serial data flop
	logic so_next;

	// Next state: bit 7 comes live so each repeat carries new contents
	always_comb begin
		idx_next = idx_reg;
		snap_next = snap_reg;
		so_next = so_reg;
		if (!active) begin
			idx_next = fsr_pkg::SER_IDX_FIRST;
		end else if (shift_en) begin
			if (idx_reg == fsr_pkg::SER_IDX_FIRST) begin
				snap_next = status_in;
				so_next = status_in[7];
			end else begin
				so_next = snap_reg[idx_reg];
			end
			// Wraps from 0 back to 7 for the repeated byte
			idx_next = idx_reg - fsr_pkg::BIT_CNT_STEP;
		end
	end

	// Registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			idx_reg <= fsr_pkg::SER_IDX_FIRST;
			snap_reg <= fsr_pkg::BYTE_RESET;
			so_reg <= fsr_pkg::SO_RESET;
		end else begin
			idx_reg <= idx_next;
			snap_reg <= snap_next;
			so_reg <= so_next;
		end
	end

	assign so_out = so_reg;

endmodule

// ---- hdl/fsr_status_regs.sv ----
// Status register and status write command logic of the serial flash
`timescale 1ns/10ps
// What this block does
// RULE1: Lock set blocks sector and global protection
// RULE2: Lock clear allows sector and global protection
// RULE3: Lock clears at reset
// RULE4: Pin asserted allows lock only 0 to 1
// RULE5: Refused lock clear ignores command, clears latch
// RULE6: Status write changes only the lock bit
// RULE7: Sequential flag shows mode, byte mode at reset
// RULE8: Error flag refreshed after each erase/program
// RULE9: Aborted operations never set error flag
// RULE10: Pin state bit reflects write protect pin
// RULE11: Summary reports none, some or all protected
// RULE12: Latch clear rejects writing commands
// RULE13: Latch clears at reset
// RULE14: Latch clears after qualifying command ends
// RULE15: Latch clears on sequential end or hold abort
// RULE16: Partial or unknown opcode keeps latch
// RULE17: Host polls status until busy falls
// RULE18: Host sets latch before status write
// RULE19: Status write is opcode plus one byte
// RULE20: Data byte: lock bit7, global bits 5..2
// RULE21: Frame end applies lock, clears latch
// RULE22: Global action from field and prior lock
// RULE23: Short data byte aborts, clears latch only
// RULE24: Summary bits 3:2, codes 00/01/11
// RULE25: Status read repeats fresh byte MSB first
// RULE26: Lock 0 to 1 may carry global action
// RULE27: Global action only when prior lock clear
// RULE28: Busy flag follows self-timed operations
module fsr_status_regs (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic ARST_N,
	// Serial port, sampled on REF_CLK
	input wire logic SCK,
	input wire logic CS_N,
	input wire logic SI,
	output logic SO,
	output logic SO_OE,
	// Write protect pin
	input wire logic WP_N,
	// Array engine side
	input wire fsr_pkg::fsr_engine_t ENGINE,
	output logic WRITE_ENABLED,
	output logic SECTORS_LOCKED,
	output logic GLOBAL_PROTECT,
	output logic GLOBAL_UNPROTECT,
	output fsr_pkg::fsr_status_t STATUS
);

	// Serial framing state
	fsr_pkg::fsr_state_t state_reg;
	fsr_pkg::fsr_state_t state_next;
	logic [2:0] cnt_reg; // Bits received in the current byte
	logic [2:0] cnt_next;
	logic [7:0] shift_reg; // Incoming bits
	logic [7:0] shift_next;
	logic [7:0] data_reg; // Captured status write byte
	logic [7:0] data_next;
	logic sck_prev_reg; // Last sampled serial clock
	logic cs_prev_n_reg; // Last sampled chip select

	// Held flags
	logic lock_reg;
	logic lock_next;
	logic wel_reg;
	logic wel_next;
	logic epe_reg;
	logic epe_next;
	logic seq_reg;
	logic seq_next;
	logic busy_reg;
	logic gprot_reg;
	logic gprot_next;
	logic gunprot_reg;
	logic gunprot_next;
	fsr_pkg::fsr_status_t status_reg;
	fsr_pkg::fsr_status_t status_next;

	// Decoded events
	logic sck_rise; // Host samples into us
	logic sck_fall; // We present the next output bit
	logic cs_end; // Frame closes this cycle
	logic [7:0] byte_in; // Byte completed at this rising edge
	logic byte_done;
	logic wr_apply; // Complete status write reaches frame end
	logic wr_refused; // Attempt to clear lock with pin asserted
	logic wr_short; // Frame ended inside the data byte
	logic wen_set;
	logic wdis_clear;
	logic [3:0] gfield;

	assign sck_rise = SCK && !sck_prev_reg;
	assign sck_fall = !SCK && sck_prev_reg;
	assign cs_end = CS_N && !cs_prev_n_reg;
	assign byte_in = {shift_reg[6:0], SI};
	assign byte_done = !CS_N && sck_rise && (cnt_reg == fsr_pkg::BIT_CNT_LAST);
	assign gfield = data_reg[fsr_pkg::WR_GLOBAL_HI:fsr_pkg::WR_GLOBAL_LO];

	// Frame end outcomes; extra trailing bytes do not matter here
	assign wr_apply = cs_end && (state_reg == fsr_pkg::FSR_ST_WR_FULL); // RULE19
	assign wr_refused = wr_apply && !WP_N && lock_reg && !data_reg[fsr_pkg::WR_LOCK_BIT]; // RULE4
	assign wr_short = cs_end && (state_reg == fsr_pkg::FSR_ST_WR_DATA);
	// Latch commands count only when closed on a byte boundary
	assign wen_set = cs_end && (state_reg == fsr_pkg::FSR_ST_WEN) && (cnt_reg == fsr_pkg::BIT_CNT_RESET);
	assign wdis_clear = cs_end && (state_reg == fsr_pkg::FSR_ST_WDIS) && (cnt_reg == fsr_pkg::BIT_CNT_RESET);

	// Frame decoder next state
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		data_next = data_reg;
		if (CS_N) begin
			// Deselected: every frame starts over with an opcode
			state_next = fsr_pkg::FSR_ST_OPCODE;
			cnt_next = fsr_pkg::BIT_CNT_RESET;
		end else if (sck_rise) begin
			shift_next = byte_in;
			cnt_next = cnt_reg + fsr_pkg::BIT_CNT_STEP;
			if (byte_done) begin
				case (state_reg)
					fsr_pkg::FSR_ST_OPCODE: begin
						if (byte_in == fsr_pkg::OPC_READ_STATUS) begin
							state_next = fsr_pkg::FSR_ST_READ; // RULE25
						end else if (byte_in == fsr_pkg::OPC_WRITE_STATUS) begin
							// Without the latch the write is rejected outright
							state_next = wel_reg ? fsr_pkg::FSR_ST_WR_DATA : fsr_pkg::FSR_ST_OTHER; // RULE12
						end else if (byte_in == fsr_pkg::OPC_WRITE_ENABLE) begin
							state_next = fsr_pkg::FSR_ST_WEN;
						end else if (byte_in == fsr_pkg::OPC_WRITE_DISABLE) begin
							state_next = fsr_pkg::FSR_ST_WDIS;
						end else begin
							// Array commands belong to the engines
							state_next = fsr_pkg::FSR_ST_OTHER;
						end
					end
					fsr_pkg::FSR_ST_WR_DATA: begin
						data_next = byte_in; // RULE20
						state_next = fsr_pkg::FSR_ST_WR_FULL;
					end
					default: begin
						// Further bytes are ignored
						state_next = state_reg; // RULE19
					end
				endcase
			end
		end
	end

	// Frame decoder registers
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_reg <= fsr_pkg::FSR_ST_OPCODE;
			cnt_reg <= fsr_pkg::BIT_CNT_RESET;
			shift_reg <= fsr_pkg::BYTE_RESET;
			data_reg <= fsr_pkg::BYTE_RESET;
			sck_prev_reg <= fsr_pkg::SCK_IDLE;
			cs_prev_n_reg <= fsr_pkg::CS_IDLE_N;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			data_reg <= data_next;
			sck_prev_reg <= SCK;
			cs_prev_n_reg <= CS_N;
		end
	end

	// Held flags next state
	always_comb begin
		lock_next = lock_reg;
		gprot_next = 1'b0;
		gunprot_next = 1'b0;
		// Only the lock bit is host writable
		if (wr_apply && !wr_refused) begin
			lock_next = data_reg[fsr_pkg::WR_LOCK_BIT]; // RULE6
			// Prior lock value gates the global action
			if (!lock_reg) begin
				gprot_next = (gfield == fsr_pkg::GLOBAL_PROTECT_CODE); // RULE22
				gunprot_next = (gfield == fsr_pkg::GLOBAL_UNPROTECT_CODE); // RULE26
			end
		end
		// Clear sources; a partial opcode reaches none of them
		wel_next = wel_reg;
		if (wr_apply || wr_short || wdis_clear || ENGINE.wel_clear) begin
			wel_next = 1'b0; // RULE14 RULE15 RULE16 RULE21 RULE23 RULE5
		end
		// Set wins over a same-cycle clear
		if (wen_set) begin
			wel_next = 1'b1;
		end
		// Aborted operations never report op_done
		epe_next = ENGINE.op_done ? ENGINE.op_fail : epe_reg; // RULE8 RULE9
		seq_next = seq_reg;
		if (ENGINE.seq_exit) begin
			seq_next = 1'b0;
		end
		if (ENGINE.seq_enter) begin
			seq_next = 1'b1; // RULE7
		end
	end

	// Status byte image, refreshed every cycle for repeated reads
	always_comb begin
		status_next.protection_lock = lock_reg;
		status_next.sequential_program_flag = seq_reg;
		status_next.erase_program_error = epe_reg;
		status_next.write_protect_pin_state = WP_N; // RULE10
		if (ENGINE.all_protected) begin
			status_next.protection_summary = fsr_pkg::SUMMARY_ALL; // RULE11 RULE24
		end else if (ENGINE.any_protected) begin
			status_next.protection_summary = fsr_pkg::SUMMARY_SOME;
		end else begin
			status_next.protection_summary = fsr_pkg::SUMMARY_NONE;
		end
		status_next.write_enable_latch = wel_reg;
		status_next.busy_flag = busy_reg;
	end

	// Held flag registers
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			lock_reg <= fsr_pkg::LOCK_RESET; // RULE3
			wel_reg <= fsr_pkg::WEL_RESET; // RULE13
			epe_reg <= fsr_pkg::EPE_RESET;
			seq_reg <= fsr_pkg::SEQ_RESET;
			busy_reg <= fsr_pkg::BUSY_RESET;
			gprot_reg <= fsr_pkg::PULSE_RESET;
			gunprot_reg <= fsr_pkg::PULSE_RESET;
			status_reg <= fsr_pkg::BYTE_RESET;
		end else begin
			lock_reg <= lock_next;
			wel_reg <= wel_next;
			epe_reg <= epe_next;
			seq_reg <= seq_next;
			busy_reg <= ENGINE.busy; // RULE28
			gprot_reg <= gprot_next;
			gunprot_reg <= gunprot_next;
			status_reg <= status_next;
		end
	end

	// Serial output of the status byte
	fsr_status_serializer u_ser (
		.clk(REF_CLK),
		.arst_n(ARST_N),
		.active(state_reg == fsr_pkg::FSR_ST_READ),
		.shift_en(sck_fall),
		.status_in(status_next),
		.so_out(SO)
	);

	// Output stays released whenever chip select is high
	assign SO_OE = !CS_N && (state_reg == fsr_pkg::FSR_ST_READ); // RULE25
	assign WRITE_ENABLED = wel_reg;
	assign SECTORS_LOCKED = lock_reg; // RULE1 RULE2
	assign GLOBAL_PROTECT = gprot_reg;
	assign GLOBAL_UNPROTECT = gunprot_reg;
	assign STATUS = status_reg;

	property p_global_needs_unlocked;
		@(posedge REF_CLK) disable iff (!ARST_N) (GLOBAL_PROTECT || GLOBAL_UNPROTECT) |-> !$past(lock_reg, 2);
	endproperty
	a_global_needs_unlocked: assert property (p_global_needs_unlocked) else $error("global action with lock set"); // RULE27

	property p_refused_keeps_lock;
		@(posedge REF_CLK) disable iff (!ARST_N) wr_refused |=> lock_reg && !wel_reg && !gprot_reg && !gunprot_reg;
	endproperty
	a_refused_keeps_lock: assert property (p_refused_keeps_lock) else $error("refused write changed state"); // RULE5

	property p_apply_takes_bit7;
		@(posedge REF_CLK) disable iff (!ARST_N)
			(wr_apply && !wr_refused && !wen_set) |=> (lock_reg == $past(data_reg[fsr_pkg::WR_LOCK_BIT])) && !wel_reg;
	endproperty
	a_apply_takes_bit7: assert property (p_apply_takes_bit7) else $error("lock not applied at frame end"); // RULE21

	property p_short_aborts;
		@(posedge REF_CLK) disable iff (!ARST_N) wr_short |=> $stable(lock_reg) && !wel_reg && !gprot_reg;
	endproperty
	a_short_aborts: assert property (p_short_aborts) else $error("short data byte not aborted"); // RULE23

	property p_wrsr_needs_wel;
		@(posedge REF_CLK) disable iff (!ARST_N)
			(byte_done && state_reg == fsr_pkg::FSR_ST_OPCODE && byte_in == fsr_pkg::OPC_WRITE_STATUS && !wel_reg)
			|=> state_reg == fsr_pkg::FSR_ST_OTHER;
	endproperty
	a_wrsr_needs_wel: assert property (p_wrsr_needs_wel) else $error("status write accepted without latch"); // RULE12

	property p_partial_keeps_wel;
		@(posedge REF_CLK) disable iff (!ARST_N)
			(cs_end && state_reg == fsr_pkg::FSR_ST_OPCODE && !ENGINE.wel_clear) |=> $stable(wel_reg);
	endproperty
	a_partial_keeps_wel: assert property (p_partial_keeps_wel) else $error("partial opcode changed latch"); // RULE16

	property p_epe_refresh;
		@(posedge REF_CLK) disable iff (!ARST_N) ENGINE.op_done |=> epe_reg == $past(ENGINE.op_fail);
	endproperty
	a_epe_refresh: assert property (p_epe_refresh) else $error("error flag not refreshed"); // RULE8

	property p_epe_hold;
		@(posedge REF_CLK) disable iff (!ARST_N) !ENGINE.op_done |=> $stable(epe_reg);
	endproperty
	a_epe_hold: assert property (p_epe_hold) else $error("error flag moved without completion"); // RULE9

	property p_busy_follows;
		@(posedge REF_CLK) disable iff (!ARST_N) ENGINE.busy |=> ##1 STATUS.busy_flag;
	endproperty
	a_busy_follows: assert property (p_busy_follows) else $error("busy flag missed engine"); // RULE28

endmodule

// ---- tb/fsr_spi_host.sv ----
// SPI host model that frames commands and status reads for the flash status logic
`timescale 1ns/10ps
module fsr_spi_host (
	// Clock
	input wire logic clk,
	// Serial port
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire logic so,
	input wire logic so_oe
);
	// Idle bus: clock parked low, chip deselected
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// One frame of nbits, MSB first, mode 0; read bits are taken just before each rise
	task automatic frame(input int nbits, input logic [23:0] tx, output logic [23:0] rx);
		rx = 24'h000000;
		@(negedge clk) cs_n = 1'b0;
		repeat (2) @(negedge clk);
		for (int i = 0; i < nbits; i++) begin
			si = tx[23 - i];
			repeat (3) @(negedge clk);
			// Undriven output reads as unknown so it can never match
			rx[23 - i] = so_oe ? so : 1'bx;
			sck = 1'b1;
			repeat (3) @(negedge clk);
			sck = 1'b0;
		end
		repeat (3) @(negedge clk);
		cs_n = 1'b1;
		// Released line must not keep showing the last bit
		si = ~si;
		repeat (4) @(negedge clk);
	endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the flash status register logic
`timescale 1ns/10ps
module tb;
	// Design stimulus and observation
	logic REF_CLK = 1'b0;
	logic ARST_N = 1'b0;
	logic WP_N = 1'b1;
	fsr_pkg::fsr_engine_t ENGINE = 8'h03;
	logic SCK, CS_N, SI, SO, SO_OE;
	logic WRITE_ENABLED, SECTORS_LOCKED, GLOBAL_PROTECT, GLOBAL_UNPROTECT;
	fsr_pkg::fsr_status_t STATUS;
	// Reference model state and global action tallies
	int m_lock, m_wel, m_epe, m_seq, m_busy, m_gp, m_gu, gp_cnt, gu_cnt;
	int num_errors, total_checks, k;
	logic [31:0] rng = 32'h0000A230;
	logic [23:0] rx;
	logic [7:0] d;

	// 10 MHz clock
	always #50 REF_CLK = ~REF_CLK;

	fsr_status_regs i_fsr_status_regs (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .SCK(SCK), .CS_N(CS_N),
		.SI(SI), .SO(SO), .SO_OE(SO_OE), .WP_N(WP_N), .ENGINE(ENGINE), .WRITE_ENABLED(WRITE_ENABLED),
		.SECTORS_LOCKED(SECTORS_LOCKED), .GLOBAL_PROTECT(GLOBAL_PROTECT),
		.GLOBAL_UNPROTECT(GLOBAL_UNPROTECT), .STATUS(STATUS));
	fsr_spi_host i_fsr_spi_host (.clk(REF_CLK), .sck(SCK), .cs_n(CS_N), .si(SI), .so(SO), .so_oe(SO_OE));

	// Count one-cycle global action pulses
	always @(posedge REF_CLK) begin
		if (GLOBAL_PROTECT === 1'b1) gp_cnt++;
		if (GLOBAL_UNPROTECT === 1'b1) gu_cnt++;
	end

	// Fixed-seed xorshift step
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	// Single comparison point
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Expected status byte from the model; summary follows engine levels
	function automatic logic [7:0] exp_status();
		logic [1:0] sm;
		sm = ENGINE.all_protected ? 2'h3 : (ENGINE.any_protected ? 2'h1 : 2'h0);
		return {m_lock[0], m_seq[0], m_epe[0], WP_N, sm, m_wel[0], m_busy[0]};
	endfunction

	// Let registered outputs settle, then compare status, latch, lock and global tallies
	task automatic chk_all();
		repeat (3) @(negedge REF_CLK);
		check("status", STATUS, exp_status());
		check("wel", {7'h00, WRITE_ENABLED}, {7'h00, m_wel[0]});
		check("lock", {7'h00, SECTORS_LOCKED}, {7'h00, m_lock[0]});
		check("gp", gp_cnt[7:0], m_gp[7:0]);
		check("gu", gu_cnt[7:0], m_gu[7:0]);
	endtask

	// Raw frame through the host model
	task automatic cmd(input int nbits, input logic [23:0] tx);
		i_fsr_spi_host.frame(nbits, tx, rx);
	endtask

	// Write enable must come first for a status write to count
	task automatic wen();
		cmd(8, {fsr_pkg::OPC_WRITE_ENABLE, 16'h0000});
		m_wel = 1;
	endtask

	// Status write, possibly short or with trailing bytes
	task automatic wrsr(input logic [7:0] dv, input int nbits);
		rng = xorshift(rng);
		cmd(nbits, {fsr_pkg::OPC_WRITE_STATUS, dv, rng[7:0]});
		if (m_wel == 1 && nbits >= 16 && !(WP_N == 1'b0 && dv[7] == 1'b0 && m_lock == 1)) begin
			if (m_lock == 0 && dv[5:2] == fsr_pkg::GLOBAL_PROTECT_CODE) m_gp++;
			if (m_lock == 0 && dv[5:2] == fsr_pkg::GLOBAL_UNPROTECT_CODE) m_gu++;
			m_lock = dv[7];
		end
		m_wel = 0;
		chk_all();
	endtask

	// Status read of two repeated bytes
	task automatic rdsr();
		cmd(24, {fsr_pkg::OPC_READ_STATUS, 16'h0000});
		check("rd0", rx[15:8], exp_status());
		check("rd1", rx[7:0], exp_status());
	endtask

	// One-cycle engine event pulse; mask bit order follows the carrier
	task automatic pulse(input logic [7:0] m);
		@(negedge REF_CLK) ENGINE = ENGINE | m;
		@(negedge REF_CLK) ENGINE = ENGINE & ~m;
	endtask

	// Verdict and end of run
	task automatic test_done();
		if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (10) @(negedge REF_CLK);
		ARST_N = 1'b1;
		chk_all();
		wrsr(8'hBC, 16);
		wen();
		chk_all();
		wrsr(8'hBC, 16);
		WP_N = 1'b0;
		wen();
		wrsr(8'h00, 16);
		wen();
		wrsr(8'hBC, 16);
		WP_N = 1'b1;
		wen();
		wrsr(8'h00, 16);
		wen();
		wrsr(8'h00, 16);
		wen();
		wrsr(8'h80, 12);
		wen();
		cmd(5, {fsr_pkg::OPC_WRITE_STATUS, 16'h0000});
		chk_all();
		// Unknown opcode closed on a byte boundary keeps the latch too
		cmd(8, {8'hE7, 16'h0000});
		chk_all();
		cmd(8, {fsr_pkg::OPC_WRITE_DISABLE, 16'h0000});
		m_wel = 0;
		chk_all();
		wen();
		wrsr(8'h80, 24);
		// Random pin level, field and don't-care bits
		for (k = 0; k < 8; k++) begin
			rng = xorshift(rng);
			WP_N = rng[16];
			d = rng[7:0];
			if (rng[8]) d[5:2] = rng[9] ? 4'hF : 4'h0;
			wen();
			wrsr(d, 16);
		end
		pulse(8'h60);
		m_epe = 1;
		chk_all();
		wen();
		pulse(8'h04);
		m_wel = 0;
		chk_all();
		pulse(8'h40);
		m_epe = 0;
		chk_all();
		// A failure flag without completion is an aborted operation
		pulse(8'h20);
		chk_all();
		pulse(8'h10);
		m_seq = 1;
		chk_all();
		pulse(8'h08);
		m_seq = 0;
		chk_all();
		for (k = 0; k < 3; k++) begin
			ENGINE.all_protected = (k == 2);
			ENGINE.any_protected = (k != 0);
			rdsr();
		end
		// Busy polling: engine finishes while the host keeps reading
		@(negedge REF_CLK) ENGINE.busy = 1'b1;
		m_busy = 1;
		rdsr();
		fork
			begin
				repeat (200) @(negedge REF_CLK);
				ENGINE.busy = 1'b0;
			end
		join_none
		rx = 24'hFFFFFF;
		// Busy is the last bit of the status byte, which lands in rx[15:8]
		for (k = 0; k < 20 && rx[8] !== 1'b0; k++) cmd(16, {fsr_pkg::OPC_READ_STATUS, 16'h0000});
		m_busy = 0;
		check("poll", {7'h00, rx[8]}, 8'h00);
		check("poll_status", rx[15:8], exp_status());
		// Second reset with lock and latch both set
		WP_N = 1'b1;
		wen();
		wrsr(8'h80, 16);
		wen();
		@(negedge REF_CLK) ARST_N = 1'b0;
		repeat (3) @(negedge REF_CLK);
		ARST_N = 1'b1;
		m_lock = 0;
		m_wel = 0;
		chk_all();
		test_done();
	end

	// Watchdog well beyond the expected run length
	initial begin
		repeat (40000) @(posedge REF_CLK);
		num_errors++;
		test_done();
	end
endmodule
